/* hdl/reset_timeout_sequencer.sv */
/*
 * Reset and start-up sequencer: qualifies brown-outs, chains the
 * power-up timer and oscillator start-up timer, tracks the reset cause,
 * the two power status bits and the time-out and power-down flags, and
 * tells the core which program counter and defaults to load.
 * Assumes arst_n is the power-on reset pulse; supply comparator, reset
 * pin, oscillator clock and timer tick are asynchronous pins.
 */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - Brown-out detection acts only while the detect-enable config bit is set.
// - A supply dip lasting past the qualification time causes brown-out reset.
// - Reset holds while supply is low, then 72 ms power-up delay follows.
// - Supply low again during power-up delay re-enters brown-out, timer restarts.
// - Power-up: power-up timer after power-on pulse, then oscillator start-up timer.
// - RC mode with power-up timer disabled: reset ends with power-on pulse.
// - Delays run regardless of the pin; pin release then starts execution at once.
// - Delay per mode and cause: 72 ms and/or 1024 oscillator cycles as tabled.
// - Power status bit 0 cleared by brown-out; software sets and checks it.
// - Power status bit 1 cleared only by power-on; software sets it afterwards.
// - Time-out and power-down flags take the per-cause encoding.
// - Resets load PC 000h; wake continues, interrupt wake with GLOBAL_INTERRUPT_ENABLE loads 0004h.
// - Status reads 0001 1xxx on power-on; watchdog reset clears time-out flag.
// - Power-on and brown-out load defaults; wake-ups leave registers unchanged.
// - Interrupt wake-up leaves a flag showing the wake source.
// - Oscillator start-up timer counts 1024 cycles, crystal modes only.
// - Internal reset stays asserted while the power-up timer runs.
// - Watchdog wake-up resumes operation without loading reset values.
module reset_timeout_sequencer
	import reset_seq_pkg::*;
#(
	parameter int POWER_UP_TIMER_TICK_COUNT = POWER_UP_TIMER_TICKS,
	parameter int OST_COUNT       = OST_CYCLES,
	parameter int BOR_COUNT       = BOR_QUAL_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              supplyLow,
	input  wire logic              masterResetN,
	input  wire logic              oscClkIn,
	input  wire logic              pwrtTick,
	input  wire logic              wdtTimeout,
	input  wire logic              sleepReq,
	input  wire logic              irqWake,
	input  wire logic              globalIntEnable,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	output logic                   coreResetN,
	output logic                   timeoutFlagN,
	output logic                   powerdownFlagN,
	output logic                   pcLoad,
	output logic      [12:0]       pcValue,
	output logic                   pcAdvance,
	output logic                   defaultsLoad,
	output logic      [2:0]        resetCause
);

	typedef enum logic [2:0] {
		ST_POWER_UP_TIMER,
		ST_OST,
		ST_BOR,
		ST_HOLD,
		ST_RUN,
		ST_SLEEP,
		ST_WAKE_OST
	} seq_state_e;

	seq_state_e            state_r;
	seq_state_e            stateNxt;
	logic [3:0]            syncA_r;
	logic [3:0]            syncB_r;
	logic [1:0]            edgeHist_r;
	logic                  supplyLowS;
	logic                  pinHighS;
	logic                  oscRise;
	logic                  tickRise;
	logic [BOR_WIDTH-1:0]  lowCount_r;
	logic                  borQualified;
	logic                  fromBor_r;
	logic                  pwrtDone;
	logic                  ostDone;
	logic [1:0]            powerStatus_r;
	logic [3:0]            config_r;
	logic [1:0]            wakeSource_r;
	logic                  borEnable;
	logic                  pwrtDisN;
	logic                  crystal;
	logic                  releaseNow;
	logic                  wakeNow;
	logic                  wakeIrq_r;
	logic                  irqVector;

	localparam logic [BOR_WIDTH-1:0] BOR_LAST = BOR_WIDTH'(BOR_COUNT);

	assign borEnable = config_r[CFG_BROWNOUT_DETECT_ENABLE_BIT];
	assign pwrtDisN  = config_r[CFG_PWRTDIS_BIT];
	assign crystal   = config_r[CFG_MODE_LSB +: 2] != MODE_RC;

	// Pins are asynchronous: two flip-flops before any logic looks at them
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_r <= 4'h0;
			syncB_r <= 4'h0;
		end else begin
			syncA_r <= {pwrtTick, oscClkIn, masterResetN, supplyLow};
			syncB_r <= syncA_r;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			edgeHist_r <= 2'h0;
		end else begin
			edgeHist_r <= syncB_r[3:2];
		end
	end

	assign supplyLowS = syncB_r[0];
	assign pinHighS   = syncB_r[1];
	// Oscillator must run below half of mclk for every cycle to be seen
	assign oscRise    = syncB_r[2] && !edgeHist_r[0];
	assign tickRise   = syncB_r[3] && !edgeHist_r[1];

	// Dip qualification; short glitches never reach the count
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lowCount_r <= '0;
		end else if (!borEnable || !supplyLowS) begin
			lowCount_r <= '0;
		end else if (lowCount_r != BOR_LAST) begin
			lowCount_r <= lowCount_r + BOR_WIDTH'(1);
		end
	end

	assign borQualified = borEnable && supplyLowS && lowCount_r == BOR_LAST;

	delay_counter #(
		.WIDTH (POWER_UP_TIMER_WIDTH),
		.TARGET(POWER_UP_TIMER_TICK_COUNT)
	) u_power_up_timer (
		.mclk  (mclk),
		.arst_n(arst_n),
		.run   (state_r == ST_POWER_UP_TIMER),
		.tick  (tickRise),
		.done  (pwrtDone)
	);

	delay_counter #(
		.WIDTH (OST_WIDTH),
		.TARGET(OST_COUNT)
	) u_ost (
		.mclk  (mclk),
		.arst_n(arst_n),
		.run   (state_r == ST_OST || state_r == ST_WAKE_OST),
		.tick  (oscRise),
		.done  (ostDone)
	);

	always_comb begin
		stateNxt = state_r;
		case (state_r)
			ST_POWER_UP_TIMER: begin
				if (borEnable && supplyLowS && fromBor_r) begin
					stateNxt = ST_BOR;
				end else if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (pwrtDone || (pwrtDisN && !fromBor_r)) begin
					stateNxt = crystal ? ST_OST : ST_HOLD;
				end
			end
			ST_OST: begin
				if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (ostDone) begin
					stateNxt = ST_HOLD;
				end
			end
			ST_BOR: begin
				if (!borEnable || !supplyLowS) begin
					stateNxt = ST_POWER_UP_TIMER;
				end
			end
			ST_HOLD: begin
				if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (pinHighS) begin
					stateNxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (!pinHighS || wdtTimeout) begin
					stateNxt = ST_HOLD;
				end else if (sleepReq) begin
					stateNxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (!pinHighS) begin
					stateNxt = ST_HOLD;
				end else if (wdtTimeout || irqWake) begin
					stateNxt = crystal ? ST_WAKE_OST : ST_RUN;
				end
			end
			ST_WAKE_OST: begin
				if (borQualified) begin
					stateNxt = ST_BOR;
				end else if (!pinHighS) begin
					stateNxt = ST_HOLD;
				end else if (ostDone) begin
					stateNxt = ST_RUN;
				end
			end
			default: begin
				stateNxt = ST_POWER_UP_TIMER;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_POWER_UP_TIMER;
		end else begin
			state_r <= stateNxt;
		end
	end

	// A brown-out always forces the full power-up delay, whatever the config says
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fromBor_r <= 1'b0;
		end else if (stateNxt == ST_BOR) begin
			fromBor_r <= 1'b1;
		end else if (stateNxt == ST_RUN) begin
			fromBor_r <= 1'b0;
		end
	end

	assign releaseNow = state_r == ST_HOLD && stateNxt == ST_RUN;
	assign wakeNow    = (state_r == ST_SLEEP || state_r == ST_WAKE_OST) && stateNxt == ST_RUN;
	// An RC wake leaves sleep in one step, before wakeIrq_r has caught up
	assign irqVector  = (state_r == ST_SLEEP ? !wdtTimeout : wakeIrq_r) && globalIntEnable;

	// Internal reset to the core
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			coreResetN <= 1'b0;
		end else begin
			coreResetN <= stateNxt == ST_RUN || stateNxt == ST_SLEEP
				|| stateNxt == ST_WAKE_OST;
		end
	end

	// Cause of the last reset or wake
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			resetCause <= CAUSE_POR;
		end else if (stateNxt == ST_BOR && state_r != ST_BOR) begin
			resetCause <= CAUSE_BOR;
		end else if (state_r == ST_RUN && stateNxt == ST_HOLD) begin
			resetCause <= wdtTimeout && pinHighS ? CAUSE_WDT_RESET : CAUSE_EXTERNAL_MASTER_RESET_N_RUN;
		end else if (state_r != ST_RUN && state_r != ST_HOLD && stateNxt == ST_HOLD
			&& state_r != ST_POWER_UP_TIMER && state_r != ST_OST) begin
			resetCause <= CAUSE_EXTERNAL_MASTER_RESET_N_SLEEP;
		end else if (state_r == ST_SLEEP && stateNxt != ST_SLEEP && stateNxt != ST_BOR
			&& stateNxt != ST_HOLD) begin
			resetCause <= wdtTimeout ? CAUSE_WDT_WAKE : CAUSE_IRQ_WAKE;
		end
	end

	// Time-out and power-down flags, active low
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			timeoutFlagN   <= 1'b1;
			powerdownFlagN <= 1'b1;
		end else if (stateNxt == ST_BOR) begin
			timeoutFlagN   <= 1'b1;
			powerdownFlagN <= 1'b1;
		end else if (state_r == ST_RUN && stateNxt == ST_HOLD && wdtTimeout && pinHighS) begin
			timeoutFlagN   <= 1'b0;
			powerdownFlagN <= 1'b1;
		end else if (state_r == ST_RUN && stateNxt == ST_SLEEP) begin
			timeoutFlagN   <= 1'b1;
			powerdownFlagN <= 1'b0;
		end else if (state_r == ST_SLEEP && stateNxt != ST_SLEEP && stateNxt != ST_BOR) begin
			timeoutFlagN   <= !(wdtTimeout && pinHighS);
			powerdownFlagN <= 1'b0;
		end
	end

	// Program counter and defaults requests; a wake-up never asks for defaults
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcLoad       <= 1'b0;
			pcValue      <= PC_RESET_VEC;
			pcAdvance    <= 1'b0;
			defaultsLoad <= 1'b0;
		end else begin
			pcLoad       <= releaseNow || (wakeNow && irqVector);
			pcValue      <= releaseNow ? PC_RESET_VEC : PC_IRQ_VEC;
			pcAdvance    <= wakeNow && !irqVector;
			defaultsLoad <= releaseNow;
		end
	end

	// Wake source stays readable after an interrupt wake
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wakeIrq_r    <= 1'b0;
			wakeSource_r <= 2'h0;
		end else if (state_r == ST_SLEEP && (wdtTimeout || irqWake) && pinHighS
			&& !borQualified) begin
			wakeIrq_r    <= !wdtTimeout;
			wakeSource_r <= {wdtTimeout, !wdtTimeout};
		end
	end

	// power_status: hardware clear wins over a software write in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			powerStatus_r <= PS_RESET;
		end else begin
			if (regWr && regAddr == OFS_POWER_STATUS) begin
				powerStatus_r <= regWrData[1:0];
			end
			if (state_r == ST_BOR) begin
				powerStatus_r[PS_BOR_BIT] <= 1'b0;
			end
		end
	end

	// Config is kept across every reset except power-on
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			config_r <= CFG_RESET;
		end else if (regWr && regAddr == OFS_CONFIG) begin
			config_r <= regWrData[3:0];
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= '0;
		end else if (regRd) begin
			case (regAddr)
				OFS_POWER_STATUS: regRdData <= {6'h00, powerStatus_r};
				OFS_CORE_STATUS:  regRdData <= {3'h0, timeoutFlagN, powerdownFlagN,
					resetCause};
				OFS_CONFIG:       regRdData <= {4'h0, config_r};
				OFS_WAKE_SOURCE:  regRdData <= {6'h00, wakeSource_r};
				default:          regRdData <= '0;
			endcase
		end else begin
			regRdData <= '0;
		end
	end

endmodule : reset_timeout_sequencer

/* hdl/reset_seq_pkg.sv */
/*
 * Constants shared by the reset and start-up sequencer: register map,
 * field positions, reset values, cause codes, program counter vectors
 * and timing counts.
 * Assumes a 10 MHz system clock.
 */
package reset_seq_pkg;

	// System clock
	localparam int CLK_FREQ_KHZ = 10000;

	// Power-up timer, counted in ticks of the internal timing oscillator
	localparam int POWER_UP_TIMER_TIME_MS     = 72;
	localparam int POWER_UP_TIMER_TICK_US     = 1000;
	localparam int POWER_UP_TIMER_TICKS       = POWER_UP_TIMER_TIME_MS * 1000 / POWER_UP_TIMER_TICK_US;
	localparam int POWER_UP_TIMER_WIDTH       = 16;

	// Oscillator start-up timer, counted in oscillator input cycles
	localparam int OST_CYCLES       = 1024;
	localparam int OST_WIDTH        = 11;

	// Least time a supply dip must last before it counts as a brown-out
	localparam int BOR_QUAL_US      = 100;
	localparam int BOR_QUAL_CYCLES  = (BOR_QUAL_US * CLK_FREQ_KHZ + 999) / 1000;
	localparam int BOR_WIDTH        = 12;

	// Register bus
	localparam int          ADDR_W           = 4;
	localparam int          DATA_W           = 8;
	localparam logic [3:0]  OFS_POWER_STATUS = 4'h0;
	localparam logic [3:0]  OFS_CORE_STATUS  = 4'h1;
	localparam logic [3:0]  OFS_CONFIG       = 4'h2;
	localparam logic [3:0]  OFS_WAKE_SOURCE  = 4'h3;

	// power_status fields
	localparam int          PS_BOR_BIT       = 0;
	localparam int          PS_POR_BIT       = 1;
	localparam logic [1:0]  PS_RESET         = 2'h0;

	// config fields
	localparam int          CFG_BROWNOUT_DETECT_ENABLE_BIT    = 0;
	localparam int          CFG_PWRTDIS_BIT  = 1;
	localparam int          CFG_MODE_LSB     = 2;
	localparam logic [3:0]  CFG_RESET        = 4'h5;

	// Oscillator modes held in config
	localparam logic [1:0]  MODE_LP          = 2'h0;
	localparam logic [1:0]  MODE_XT          = 2'h1;
	localparam logic [1:0]  MODE_HS          = 2'h2;
	localparam logic [1:0]  MODE_RC          = 2'h3;

	// core_status fields, laid out as in the processor status register
	localparam int          CS_TO_BIT        = 4;
	localparam int          CS_PD_BIT        = 3;

	// Cause of the last reset or wake-up
	localparam logic [2:0]  CAUSE_POR        = 3'h0;
	localparam logic [2:0]  CAUSE_BOR        = 3'h1;
	localparam logic [2:0]  CAUSE_EXTERNAL_MASTER_RESET_N_RUN   = 3'h2;
	localparam logic [2:0]  CAUSE_EXTERNAL_MASTER_RESET_N_SLEEP = 3'h3;
	localparam logic [2:0]  CAUSE_WDT_RESET  = 3'h4;
	localparam logic [2:0]  CAUSE_WDT_WAKE   = 3'h5;
	localparam logic [2:0]  CAUSE_IRQ_WAKE   = 3'h6;

	// Program counter vectors
	localparam logic [12:0] PC_RESET_VEC     = 13'h0000;
	localparam logic [12:0] PC_IRQ_VEC       = 13'h0004;

	// Register defaults applied by the core on power-on and brown-out
	localparam logic [7:0]  OPTION_DEFAULT   = 8'hFF;
	localparam logic [7:0]  TRIS_DEFAULT     = 8'hFF;
	localparam logic [7:0]  INTCTL_DEFAULT   = 8'h00;

endpackage : reset_seq_pkg

/* hdl/delay_counter.sv */
/*
 * Tick counter for one start-up delay stage.
 * Assumes tick is a one-cycle pulse on the same clock; the count
 * clears whenever run is low, so re-entering a stage restarts it.
 */
`timescale 1ns/1ns
module delay_counter #(
	parameter int WIDTH  = 16,
	parameter int TARGET = 72
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic run,
	input  wire logic tick,
	output logic      done
);
	localparam logic [WIDTH-1:0] LAST = WIDTH'(TARGET);

	logic [WIDTH-1:0] count_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= '0;
		end else if (!run) begin
			count_r <= '0;
		end else if (tick && count_r != LAST) begin
			count_r <= count_r + WIDTH'(1);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			done <= 1'b0;
		end else begin
			done <= run && (count_r == LAST);
		end
	end

endmodule : delay_counter

/* tb/reset_seq_monitor.sv */
/*
 * Port checker for reset_timeout_sequencer.
 * Assumes a bind onto the top module and one clock domain.
 */
`timescale 1ns/1ns
module reset_seq_monitor
	import reset_seq_pkg::*;
(
	input wire logic              mclk,
	input wire logic              arst_n,
	input wire logic              masterResetN,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regRd,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic              coreResetN,
	input wire logic              timeoutFlagN,
	input wire logic              powerdownFlagN,
	input wire logic              pcLoad,
	input wire logic [12:0]       pcValue,
	input wire logic              pcAdvance,
	input wire logic              defaultsLoad,
	input wire logic [2:0]        resetCause
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_load_single_pulse: assert property (pcLoad |=> !pcLoad)
		else $error("pc load longer than one cycle");
	a_defaults_reset_vector: assert property (defaultsLoad |->
		pcLoad && pcValue == PC_RESET_VEC && $rose(coreResetN))
		else $error("defaults load without reset vector");
	a_wake_keeps_regs: assert property (pcAdvance |->
		coreResetN && !defaultsLoad && !pcLoad)
		else $error("wake-up reloaded state");
	a_irq_vector_cause: assert property (pcLoad && pcValue == PC_IRQ_VEC |->
		resetCause == CAUSE_IRQ_WAKE && !defaultsLoad)
		else $error("interrupt vector without interrupt wake");
	// Six cycles covers the pin synchroniser and the hold decision
	a_pin_holds_reset: assert property ((!masterResetN) [*6] |-> !coreResetN)
		else $error("core runs with pin low");
	a_release_after_pin: assert property ($rose(coreResetN) |-> $past(masterResetN, 2))
		else $error("core released before pin high");
	a_por_flags_set: assert property (!coreResetN && resetCause == CAUSE_POR |->
		timeoutFlagN && powerdownFlagN)
		else $error("power-on flags wrong");
	a_bor_flags_set: assert property (!coreResetN && resetCause == CAUSE_BOR |->
		timeoutFlagN && powerdownFlagN)
		else $error("brown-out flags wrong");
	a_wdt_reset_flags: assert property (!coreResetN && resetCause == CAUSE_WDT_RESET |->
		!timeoutFlagN && powerdownFlagN)
		else $error("watchdog reset flags wrong");
	a_status_readback: assert property (regRd && regAddr == OFS_CORE_STATUS |=>
		regRdData == {3'h0, $past(timeoutFlagN), $past(powerdownFlagN), $past(resetCause)})
		else $error("core status read wrong");
	a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data not zero when idle");
endmodule : reset_seq_monitor

/* tb/core_env_model.sv */
/*
 * Far-side model: oscillator, timer tick and a core PC following
 * the load and advance pulses. Assumes a 10 MHz system clock.
 */
`timescale 1ns/1ns
module core_env_model (
	input  wire logic        mclk,
	input  wire logic        pcLoad,
	input  wire logic [12:0] pcValue,
	input  wire logic        pcAdvance,
	output logic             oscClkIn,
	output logic             pwrtTick,
	output logic      [12:0] pc
);
	// Kept well below half of mclk so the synchronisers see every edge
	initial begin
		oscClkIn = 1'h0;
		pwrtTick = 1'h0;
	end
	always #300 oscClkIn = ~oscClkIn;
	always #350 pwrtTick = ~pwrtTick;
	always_ff @(posedge mclk) begin
		if (pcLoad) begin
			pc <= pcValue;
		end else if (pcAdvance) begin
			pc <= pc + 13'h0001;
		end
	end
endmodule : core_env_model

/* tb/reset_timeout_sequencer_tb.sv */
/*
 * Bench for reset_timeout_sequencer: power-on, registers, wakes,
 * pin and watchdog resets, brown-outs.
 * Assumes core_env_model drives oscillator, tick and core PC.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module reset_timeout_sequencer_tb
	import reset_seq_pkg::*;
;
	logic              mclk = 1'h0;
	logic              arst_n = 1'h0;
	logic              supplyLow = 1'h0;
	logic              masterResetN = 1'h0;
	logic              wdtTimeout = 1'h0;
	logic              sleepReq = 1'h0;
	logic              irqWake = 1'h0;
	logic              globalIntEnable = 1'h0;
	logic [ADDR_W-1:0] regAddr = 4'h0;
	logic [DATA_W-1:0] regWrData = 8'h00;
	logic              regWr = 1'h0;
	logic              regRd = 1'h0;
	logic [DATA_W-1:0] regRdData, rv;
	logic              coreResetN, timeoutFlagN, powerdownFlagN;
	logic              pcLoad, pcAdvance, defaultsLoad, oscClkIn, pwrtTick;
	logic [12:0]       pcValue, pc;
	logic [2:0]        resetCause;
	int                num_errors = 0;
	int                num_checks = 0;
	int                n;

	always #50 mclk = ~mclk;

	reset_timeout_sequencer #(.POWER_UP_TIMER_TICK_COUNT(3), .OST_COUNT(8), .BOR_COUNT(4))
		reset_timeout_sequencer_inst (.mclk, .arst_n, .supplyLow, .masterResetN, .oscClkIn,
		.pwrtTick, .wdtTimeout, .sleepReq, .irqWake, .globalIntEnable, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .coreResetN, .timeoutFlagN,
		.powerdownFlagN, .pcLoad, .pcValue, .pcAdvance, .defaultsLoad, .resetCause);
	core_env_model core_env_model_inst (.mclk, .pcLoad, .pcValue, .pcAdvance, .oscClkIn,
		.pwrtTick, .pc);

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge mclk);
		regWr <= 1'h0;
	endtask : wr

	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input string nm, input logic [DATA_W-1:0] m = 8'hFF);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge mclk);
		regRd <= 1'h0;
		@(negedge mclk);
		rv = regRdData & m;
		`CHK(nm, e, rv)
	endtask : rdChk

	task automatic waitRst(input logic lvl, input int lim);
		for (n = 0; n < lim && coreResetN !== lvl; n++) @(negedge mclk);
		`CHK("coreResetN", lvl, coreResetN)
		if (n == lim) summarize();
		@(negedge mclk);
	endtask : waitRst

	task automatic dip(input int len);
		@(posedge mclk);
		supplyLow <= 1'h1;
		repeat (len) @(posedge mclk);
		supplyLow <= 1'h0;
	endtask : dip

	task automatic wake(input logic wdt, input logic global_interrupt_enable, input logic [12:0] epc,
		input logic [7:0] est);
		@(posedge mclk);
		globalIntEnable <= global_interrupt_enable;
		sleepReq <= 1'h1;
		@(posedge mclk);
		sleepReq <= 1'h0;
		repeat (4) @(posedge mclk);
		`CHK("powerdownFlagN", 1'h0, powerdownFlagN)
		wdtTimeout <= wdt;
		irqWake <= !wdt;
		@(posedge mclk);
		wdtTimeout <= 1'h0;
		// Interrupt stays pending until the core resumes
		for (n = 0; n < 400 && pc !== epc; n++) @(posedge mclk);
		irqWake <= 1'h0;
		`CHK("pc after wake", epc, pc)
		if (n == 400) summarize();
		`CHK("coreResetN in wake", 1'h1, coreResetN)
		rdChk(OFS_CORE_STATUS, est, "status wake");
		rdChk(OFS_WAKE_SOURCE, {6'h00, wdt, !wdt}, "wake source", {6'h00, wdt, !wdt});
		$display("wake test done");
	endtask : wake

	task automatic resetSeq(input int kind, input logic [7:0] est);
		@(posedge mclk);
		sleepReq <= (kind == 1);
		@(posedge mclk);
		sleepReq <= 1'h0;
		masterResetN <= (kind == 2);
		wdtTimeout <= (kind == 2);
		@(posedge mclk);
		wdtTimeout <= 1'h0;
		waitRst(1'h0, 10);
		rdChk(OFS_CORE_STATUS, est, "status reset");
		@(posedge mclk);
		masterResetN <= 1'h1;
		waitRst(1'h1, 10);
		`CHK("pc after reset", PC_RESET_VEC, pc)
		rdChk(OFS_POWER_STATUS, 8'h03, "power_status kept");
		$display("reset test done");
	endtask : resetSeq

	initial begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'h1;
		// Pin held low well past the start-up delays
		repeat (200) @(posedge mclk);
		`CHK("coreResetN pin low", 1'h0, coreResetN)
		masterResetN <= 1'h1;
		waitRst(1'h1, 10);
		`CHK("pc power-on", PC_RESET_VEC, pc)
		rdChk(OFS_CORE_STATUS, 8'h18, "status power-on");
		rdChk(OFS_POWER_STATUS, 8'h00, "power_status power-on");
		rdChk(OFS_CONFIG, 8'h05, "config reset");
		wr(OFS_POWER_STATUS, 8'h03);
		rdChk(OFS_POWER_STATUS, 8'h03, "power_status set");
		wr(OFS_CORE_STATUS, 8'hFF);
		rdChk(OFS_CORE_STATUS, 8'h18, "status read-only");
		rdChk(4'hF, 8'h00, "unmapped read");
		$display("power-on test done");
		wake(1'h1, 1'h0, 13'h0001, 8'h05);
		resetSeq(0, 8'h02);
		wake(1'h0, 1'h0, 13'h0001, 8'h16);
		wake(1'h0, 1'h1, PC_IRQ_VEC, 8'h16);
		resetSeq(1, 8'h13);
		wake(1'h1, 1'h0, 13'h0001, 8'h05);
		resetSeq(2, 8'h0C);
		wr(OFS_CONFIG, 8'h04);
		dip(30);
		repeat (8) @(posedge mclk);
		`CHK("coreResetN detect off", 1'h1, coreResetN)
		wr(OFS_CONFIG, 8'h05);
		dip(2);
		repeat (8) @(posedge mclk);
		`CHK("coreResetN short dip", 1'h1, coreResetN)
		// Crystal mode first, then resistor-capacitor mode
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CONFIG, i ? 8'h0D : 8'h05);
			dip(20);
			`CHK("coreResetN brown-out", 1'h0, coreResetN)
			repeat (10) @(posedge mclk);
			dip(20);
			waitRst(1'h1, 400);
			`CHK("brown-out delay", 1'h1, i ? (n >= 14 && n < 45) : (n >= 56))
			rdChk(OFS_CORE_STATUS, 8'h19, "status brown-out");
			rdChk(OFS_POWER_STATUS, 8'h02, "power_status brown-out");
			wr(OFS_POWER_STATUS, 8'h03);
			$display("brown-out test done");
		end
		// Still in RC mode: the wake has no start-up delay and must vector at once
		wake(1'h0, 1'h1, PC_IRQ_VEC, 8'h16);
		summarize();
	end
endmodule : reset_timeout_sequencer_tb

bind reset_timeout_sequencer reset_seq_monitor reset_seq_monitor_inst (.mclk, .arst_n,
	.masterResetN, .regAddr, .regRd, .regRdData, .coreResetN, .timeoutFlagN,
	.powerdownFlagN, .pcLoad, .pcValue, .pcAdvance, .defaultsLoad, .resetCause);
